//--- txn_ctrl_consts.svh
// Register offsets, field positions, codes and timing counts for transaction control
`ifndef TXN_CTRL_CONSTS_SVH
`define TXN_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATE_STATUS   6'h02
`define REG_RETRY_CFG      6'h2C

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CMD_MSB            4
`define RESULT_LSB         5
`define RETRY_LSB          4
`define RETRY_CFG_RESET    8'h30

// ----------------------------------------------------------------
// State command codes
// ----------------------------------------------------------------
`define CMD_NOP            5'h00
`define CMD_TX_START       5'h02
`define CMD_RX_LISTEN      5'h06
`define CMD_PLL_ON         5'h09
`define CMD_AACK_ON        5'h16
`define CMD_ARET_ON        5'h19

// ----------------------------------------------------------------
// State readback codes
// ----------------------------------------------------------------
`define STS_RX_LISTEN      5'h06
`define STS_PLL_ON         5'h09
`define STS_AACK_ON        5'h16
`define STS_ARET_IDLE      5'h19
`define STS_ARET_BUSY      5'h12

// ----------------------------------------------------------------
// Transaction results
// ----------------------------------------------------------------
`define RES_SUCCESS        3'h0
`define RES_NO_ACK         3'h5

// ----------------------------------------------------------------
// Frame fields
// ----------------------------------------------------------------
`define FT_BEACON          3'h0
`define FT_DATA            3'h1
`define FT_COMMAND         3'h3
`define AM_EXTENDED        2'h3
`define BROADCAST          16'hFFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ             50000000
`define SYMBOL_NS          16000
`define SYMBOL_CYCLES      ((`SYMBOL_NS * (`CLK_HZ / 1000000)) / 1000)
`define ACK_WAIT_SYMBOLS   46
`define LATE_END_SYMBOLS   2

`endif

//--- txn_ctrl_pkg.sv
// Types shared by the transaction control block
package txn_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_PLL_ON    = 3'b000,
    ST_RX_LISTEN = 3'b001,
    ST_AACK      = 3'b010,
    ST_ARET_IDLE = 3'b011,
    ST_ARET_TX   = 3'b100,
    ST_ARET_WAIT = 3'b101,
    ST_ARET_END  = 3'b110
  } ctrlState_e;

  typedef struct packed {
    logic [2:0]  frameType;
    logic        ackRequest;
    logic [1:0]  dstAddrMode;
    logic [15:0] dstPan;
    logic [15:0] dstShort;
    logic        dstLongMatch;
  } rxHeader_s;

  typedef struct packed {
    logic        upload;
    logic        sendAck;
  } filterResult_s;

endpackage : txn_ctrl_pkg

//--- symbol_tick.sv
// Symbol-rate enable divider, restarted whenever it is not running
`include "txn_ctrl_consts.svh"

module symbol_tick
  import txn_ctrl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetSync_n,
  input  wire logic run,
  output logic      tick
);

  localparam logic [15:0] LAST = 16'(`SYMBOL_CYCLES - 1);

  logic [15:0] count;

  assign tick = run && (count == LAST);

  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      count <= 16'h0000;
    end else if (!run || tick) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

endmodule : symbol_tick

//--- frame_filter.sv
// Upload and acknowledge decision for a frame received in auto-acknowledge mode
`include "txn_ctrl_consts.svh"

module frame_filter
  import txn_ctrl_pkg::*;
(
  input  rxHeader_s     header,
  input  wire logic [15:0] ownPan,
  input  wire logic [15:0] ownShort,
  output filterResult_s result
);

  wire isData    = header.frameType == `FT_DATA;
  wire isCommand = header.frameType == `FT_COMMAND;
  wire isBeacon  = header.frameType == `FT_BEACON;
  wire bcastAddr = header.dstShort == `BROADCAST;
  wire bcastPan  = header.dstPan == `BROADCAST;
  wire extMode   = header.dstAddrMode == `AM_EXTENDED;
  wire panOk     = bcastPan || (header.dstPan == ownPan);
  wire addrOk    = extMode ? header.dstLongMatch : (bcastAddr || header.dstShort == ownShort);
  wire dataOk    = (isData || isCommand) && panOk && addrOk;
  // Broadcast PAN with long addressing is lost, so orphan scans need basic mode
  wire dropExt   = (isData || isCommand) && bcastPan && extMode;                  // RULE_02
  // Beacons vanish while our own PAN is still unassigned
  wire dropBeacon = isBeacon && (ownPan == `BROADCAST);                           // RULE_03

  assign result.upload  = (dataOk && !dropExt) || (isBeacon && !dropBeacon);
  // Broadcast data with acknowledge request is still answered
  assign result.sendAck = dataOk && header.ackRequest;                            // RULE_01

endmodule : frame_filter

//--- txn_ctrl.sv
// Extended-mode transaction control: auto-acknowledge, auto-retry and channel assessment
//
// Summary of operation
// RULE_01: Auto-acknowledge acknowledges broadcast data frames that request acknowledgment.
// RULE_02: Auto-acknowledge drops data/command frames with broadcast PAN and long address.
// RULE_03: Auto-acknowledge drops beacons while own PAN identifier is broadcast.
// RULE_04: Preamble at acknowledge-wait end finishes at once, interrupt, result stays success.
// RULE_05: Maximum retry count zero means no retransmissions.
// RULE_06: Transmit frame stays buffered; a repeat needs only another transmit start.
// RULE_07: Receive-listen command during busy retry is deferred until busy ends.
// RULE_08: Deferred receive-listen catches late frame and keeps result at no-acknowledge.
// RULE_09: Acknowledge wait lasts 46 symbols.
// RULE_10: End interrupt may come late when retransmissions happened.
// RULE_11: Assessment request may be dropped; done flag then shows in progress.
// RULE_12: Host reaches assessment via pll-on, receive-listen, then immediate request.
// RULE_13: Host follows the documented auto-retry command and polling order.
// RULE_14: Continuous-wave interference may raise receive-start interrupts and block frames.
// RULE_15: Host sends only compliant frames, no broadcast data asking acknowledgment.
// RULE_16: Host uses basic mode for orphan and network scans.
`include "txn_ctrl_consts.svh"

module txn_ctrl
  import txn_ctrl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register access from the serial interface
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [5:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic [7:0]       regRdata,
  // Own addressing
  input  wire logic [15:0] ownPan,
  input  wire logic [15:0] ownShort,
  // Receiver events
  input  wire logic        preambleDetect,
  input  wire logic        rxFrameValid,
  input  rxHeader_s        rxHeader,
  input  wire logic        ackFrameValid,
  // Transmitter
  input  wire logic        txAckRequest,
  input  wire logic        txDone,
  output logic             txStart,
  output logic             ackStart,
  output logic             frameUpload,
  // Channel assessment
  input  wire logic        ccaRequest,
  input  wire logic        ccaFinished,
  output logic             ccaStart,
  output logic             ccaDone,
  // Interrupts
  output logic             trxEndIrq,
  output logic             rxStartIrq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       resetMeta_n;
  logic       resetSync_n;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resetMeta_n <= 1'b0;
      resetSync_n <= 1'b0;
    end else begin
      resetMeta_n <= 1'b1;
      resetSync_n <= resetMeta_n;
    end
  end

  // ----------------------------------------------------------------
  // Registers and command decode
  // ----------------------------------------------------------------
  ctrlState_e state;
  ctrlState_e next_state;
  logic [2:0] result;
  logic [7:0] retryCfg;
  logic [3:0] retriesDone;
  logic       pendingRx;
  logic [5:0] waitSymbols;
  logic [1:0] lateSymbols;
  logic       preambleSeen;
  logic       ccaArmed;
  logic [4:0] stateCode;

  wire        hitStatus  = regAddr == `REG_STATE_STATUS;
  wire        hitRetry   = regAddr == `REG_RETRY_CFG;
  wire        cmdWrite   = regWrite && hitStatus;
  wire [4:0]  cmd        = regWdata[`CMD_MSB:0];
  wire [3:0]  maxRetries = retryCfg[7:`RETRY_LSB];
  wire        busy       = state == ST_ARET_TX || state == ST_ARET_WAIT || state == ST_ARET_END;
  wire        listening  = state == ST_RX_LISTEN || state == ST_AACK || state == ST_ARET_WAIT;

  always_comb begin
    case (state)
      ST_PLL_ON:    stateCode = `STS_PLL_ON;
      ST_RX_LISTEN: stateCode = `STS_RX_LISTEN;
      ST_AACK:      stateCode = `STS_AACK_ON;
      ST_ARET_IDLE: stateCode = `STS_ARET_IDLE;
      default:      stateCode = `STS_ARET_BUSY;
    endcase
  end

  wire [7:0]  readValue = hitStatus ? {result, stateCode} :
                          hitRetry  ? retryCfg : 8'h00;

  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      regRdata <= 8'h00;
      retryCfg <= `RETRY_CFG_RESET;
    end else begin
      if (regRead) begin
        regRdata <= readValue;
      end
      if (regWrite && hitRetry) begin
        retryCfg <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Symbol timing
  // ----------------------------------------------------------------
  wire        symTick;
  wire        symRun = state == ST_ARET_WAIT || state == ST_ARET_END;

  symbol_tick u_symbolTick (
    .clk_sys     (clk_sys),
    .resetSync_n (resetSync_n),
    .run         (symRun),
    .tick        (symTick)
  );

  wire        waitEnd = symTick && (waitSymbols == 6'(`ACK_WAIT_SYMBOLS - 1));  // RULE_09
  // Retransmissions stretch the end of the procedure by a few symbols
  wire        lateDone = (retriesDone == 4'h0) ||
                         (symTick && lateSymbols == 2'(`LATE_END_SYMBOLS - 1)); // RULE_10
  wire        canRetry = retriesDone < maxRetries;                              // RULE_05

  // ----------------------------------------------------------------
  // Frame filter
  // ----------------------------------------------------------------
  filterResult_s filt;

  frame_filter u_frameFilter (
    .header   (rxHeader),
    .ownPan   (ownPan),
    .ownShort (ownShort),
    .result   (filt)
  );

  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_PLL_ON, ST_RX_LISTEN, ST_AACK, ST_ARET_IDLE: begin
        if (cmdWrite) begin
          case (cmd)
            `CMD_PLL_ON:    next_state = ST_PLL_ON;
            `CMD_RX_LISTEN: next_state = ST_RX_LISTEN;
            `CMD_AACK_ON:   next_state = ST_AACK;
            `CMD_ARET_ON:   next_state = ST_ARET_IDLE;
            `CMD_TX_START:  next_state = (state == ST_ARET_IDLE) ? ST_ARET_TX : state;
            default:        next_state = state;
          endcase
        end
      end
      ST_ARET_TX: begin
        if (txDone) begin
          next_state = txAckRequest ? ST_ARET_WAIT : ST_ARET_END;
        end
      end
      ST_ARET_WAIT: begin
        if (ackFrameValid) begin
          next_state = ST_ARET_END;
        end else if (waitEnd) begin
          // A preamble seen any time in the wait ends the procedure at the deadline
          if (preambleSeen || !canRetry) begin                                 // RULE_04
            next_state = ST_ARET_END;
          end else begin
            next_state = ST_ARET_TX;
          end
        end
      end
      ST_ARET_END: begin
        if (lateDone) begin
          next_state = pendingRx ? ST_RX_LISTEN : ST_ARET_IDLE;                // RULE_07
        end
      end
      default: next_state = ST_PLL_ON;
    endcase
  end

  wire        enterTx   = next_state == ST_ARET_TX && state != ST_ARET_TX;
  wire        startTxn  = state == ST_ARET_IDLE && next_state == ST_ARET_TX;
  wire        retryNow  = state == ST_ARET_WAIT && next_state == ST_ARET_TX;
  wire        noAckEnd  = state == ST_ARET_WAIT && waitEnd && !ackFrameValid &&
                          (!preambleSeen || pendingRx);                         // RULE_08
  wire        endNow    = state == ST_ARET_END && lateDone;
  wire        enterRx   = next_state == ST_RX_LISTEN && state != ST_RX_LISTEN;
  wire        aackFrame = state == ST_AACK && rxFrameValid;

  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      state <= ST_PLL_ON;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Auto-retry bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      result       <= `RES_SUCCESS;
      retriesDone  <= 4'h0;
      pendingRx    <= 1'b0;
      waitSymbols  <= 6'h00;
      lateSymbols  <= 2'h0;
      preambleSeen <= 1'b0;
    end else begin
      if (startTxn) begin
        result      <= `RES_SUCCESS;
        retriesDone <= 4'h0;
      end else if (retryNow) begin
        retriesDone <= retriesDone + 4'h1;                                     // RULE_05
      end
      if (noAckEnd) begin
        result <= `RES_NO_ACK;                                                 // RULE_08
      end
      if (busy && cmdWrite && cmd == `CMD_RX_LISTEN) begin
        pendingRx <= 1'b1;                                                     // RULE_07
      end else if (endNow) begin
        pendingRx <= 1'b0;
      end
      if (state != ST_ARET_WAIT) begin
        waitSymbols <= 6'h00;
      end else if (symTick) begin
        waitSymbols <= waitSymbols + 6'h01;
      end
      if (state != ST_ARET_END) begin
        lateSymbols <= 2'h0;
      end else if (symTick) begin
        lateSymbols <= lateSymbols + 2'h1;
      end
      if (state != ST_ARET_WAIT) begin
        preambleSeen <= 1'b0;
      end else if (preambleDetect) begin
        preambleSeen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobes to the radio and interrupts
  // ----------------------------------------------------------------
  logic preamblePrev;

  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      txStart      <= 1'b0;
      ackStart     <= 1'b0;
      frameUpload  <= 1'b0;
      trxEndIrq    <= 1'b0;
      rxStartIrq   <= 1'b0;
      preamblePrev <= 1'b0;
    end else begin
      // Frame buffer is never invalidated, so a repeat sends the same bytes
      txStart      <= enterTx;                                                 // RULE_06
      ackStart     <= aackFrame && filt.sendAck;                               // RULE_01
      frameUpload  <= aackFrame ? filt.upload : (state == ST_RX_LISTEN && rxFrameValid);
      trxEndIrq    <= endNow || aackFrame;                                     // RULE_04
      preamblePrev <= preambleDetect;
      // Any in-band carrier, wanted or not, looks like a frame start
      rxStartIrq   <= listening && preambleDetect && !preamblePrev;            // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // Channel assessment
  // ----------------------------------------------------------------
  wire        ccaAccept = state == ST_RX_LISTEN && ccaRequest && ccaArmed;

  always_ff @(posedge clk_sys or negedge resetSync_n) begin
    if (!resetSync_n) begin
      ccaArmed <= 1'b0;
      ccaStart <= 1'b0;
      ccaDone  <= 1'b1;
    end else begin
      ccaStart <= ccaAccept;
      // Only the first request after entering listen is honoured
      if (enterRx) begin
        ccaArmed <= 1'b1;
      end else if (ccaRequest) begin
        ccaArmed <= 1'b0;
      end
      if (ccaFinished) begin
        ccaDone <= 1'b1;
      end else if (ccaRequest) begin
        ccaDone <= 1'b0;                                                       // RULE_11
      end
    end
  end

endmodule : txn_ctrl

//--- txn_ctrl_chk.sv
// Port-level assertions for the transaction control block
`include "txn_ctrl_consts.svh"

module txn_ctrl_chk
  import txn_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] ownPan,
  input wire logic preambleDetect,
  input wire logic rxFrameValid,
  input rxHeader_s rxHeader,
  input wire logic ackFrameValid,
  input wire logic txAckRequest,
  input wire logic txDone,
  input wire logic txStart,
  input wire logic ackStart,
  input wire logic frameUpload,
  input wire logic ccaRequest,
  input wire logic ccaFinished,
  input wire logic ccaStart,
  input wire logic ccaDone,
  input wire logic trxEndIrq,
  input wire logic rxStartIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT = `ACK_WAIT_SYMBOLS * `SYMBOL_CYCLES;
  localparam int LATE = WAIT + `LATE_END_SYMBOLS * `SYMBOL_CYCLES + 8;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  wire dataOrCmd = rxHeader.frameType == `FT_DATA || rxHeader.frameType == `FT_COMMAND;
  wire extBcast  = dataOrCmd && rxHeader.dstPan == `BROADCAST
                   && rxHeader.dstAddrMode == `AM_EXTENDED;
  wire bcnOwnBc  = rxHeader.frameType == `FT_BEACON && ownPan == `BROADCAST;

  // Cycles since the frame went out; zero when no ack wait runs
  logic [16:0] waitCnt;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) waitCnt <= '0;
    else if (txDone && txAckRequest) waitCnt <= 17'd1;
    else if (ackFrameValid || txStart || trxEndIrq) waitCnt <= '0;
    else if (waitCnt != 0) waitCnt <= waitCnt + 17'd1;
  end

  chk_ack_needs_req: assert property (ackStart |-> $past(rxFrameValid && rxHeader.ackRequest))
    else $error("ack sent without a request");
  chk_ack_ends_txn: assert property (ackStart |-> trxEndIrq)
    else $error("ack without end interrupt");
  chk_no_ext_upload: assert property (frameUpload && trxEndIrq |-> !$past(extBcast))
    else $error("extended broadcast frame uploaded");
  chk_no_beacon_upload: assert property (frameUpload && trxEndIrq |-> !$past(bcnOwnBc))
    else $error("beacon uploaded with broadcast own id");
  chk_wait_span: assert property (trxEndIrq && waitCnt != 0 |-> waitCnt >= WAIT && waitCnt <= LATE)
    else $error("ack wait length off");
  chk_cca_start_cause: assert property (ccaStart |-> $past(ccaRequest))
    else $error("assessment started unasked");
  chk_cca_busy_flag: assert property (ccaStart |-> !ccaDone)
    else $error("done flag high while assessing");
  chk_cca_finish_done: assert property (ccaFinished |=> ccaDone)
    else $error("done flag low after finish");
  chk_assessment_done_flag_cause: assert property ($rose(ccaDone) |-> $past(ccaFinished))
    else $error("done flag rose without finish");
  chk_rxstart_cause: assert property (rxStartIrq |-> $past(preambleDetect))
    else $error("receive start without preamble");

  cover property (ackStart);
  cover property (trxEndIrq && waitCnt != 0);
  cover property (ccaStart);
endmodule : txn_ctrl_chk

bind txn_ctrl txn_ctrl_chk chk_u (
  .clk_sys(clk_sys), .reset_n(reset_n), .ownPan(ownPan), .preambleDetect(preambleDetect),
  .rxFrameValid(rxFrameValid), .rxHeader(rxHeader), .ackFrameValid(ackFrameValid),
  .txAckRequest(txAckRequest), .txDone(txDone), .txStart(txStart), .ackStart(ackStart),
  .frameUpload(frameUpload), .ccaRequest(ccaRequest), .ccaFinished(ccaFinished),
  .ccaStart(ccaStart), .ccaDone(ccaDone), .trxEndIrq(trxEndIrq), .rxStartIrq(rxStartIrq)
);

//--- radio_model.sv
// Transmitter and assessment engine stand-in facing the control block
module radio_model (
  input  wire logic clk_sys,
  input  wire logic txStart,
  input  wire logic ccaStart,
  output logic      txDone,
  output logic      ccaFinished
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed three-cycle answer keeps the ack wait arithmetic simple
  logic [2:0] txPipe  = 3'h0;
  logic [2:0] ccaPipe = 3'h0;
  always @(posedge clk_sys) begin
    txPipe  <= {txPipe[1:0], txStart};
    ccaPipe <= {ccaPipe[1:0], ccaStart};
  end
  assign txDone      = txPipe[2];
  assign ccaFinished = ccaPipe[2];
endmodule : radio_model

//--- testbench.sv
// Directed bench for the transaction control block
`include "txn_ctrl_consts.svh"

module testbench
  import txn_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = `ACK_WAIT_SYMBOLS * `SYMBOL_CYCLES;
  localparam logic [5:0] SS = `REG_STATE_STATUS;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite, regRead, preambleDetect, rxFrameValid, ackFrameValid, ccaRequest;
  logic txDone, txStart, ackStart, frameUpload, ccaFinished, ccaStart, ccaDone;
  logic trxEndIrq, rxStartIrq;
  logic txAckRequest = 1'b1;
  logic [5:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic [15:0] ownPan;
  rxHeader_s   rxHeader;
  int errTotal = 0, checksDone = 0, txCnt = 0, ccaCnt = 0, rxsCnt = 0, t;

  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (txStart === 1'b1) txCnt++;
    if (ccaStart === 1'b1) ccaCnt++;
    if (rxStartIrq === 1'b1) rxsCnt++;
  end

  txn_ctrl dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .ownPan(ownPan),
    .ownShort(16'h0001), .preambleDetect(preambleDetect), .rxFrameValid(rxFrameValid),
    .rxHeader(rxHeader), .ackFrameValid(ackFrameValid), .txAckRequest(txAckRequest),
    .txDone(txDone), .txStart(txStart), .ackStart(ackStart), .frameUpload(frameUpload),
    .ccaRequest(ccaRequest), .ccaFinished(ccaFinished), .ccaStart(ccaStart),
    .ccaDone(ccaDone), .trxEndIrq(trxEndIrq), .rxStartIrq(rxStartIrq)
  );
  radio_model radio_u (
    .clk_sys(clk_sys), .txStart(txStart), .ccaStart(ccaStart),
    .txDone(txDone), .ccaFinished(ccaFinished)
  );

  task finalReport;
    if (errTotal == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finalReport

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [5:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    tick(1);
    regWrite = 1'b0;
    tick(1);
  endtask : wr

  task rd(input logic [5:0] a, input logic [7:0] exp);
    regAddr = a;
    regRead = 1'b1;
    tick(1);
    regRead = 1'b0;
    tick(1);
    check(regRdata, exp);
  endtask : rd

  task waitIrq(input int lim);
    t = 0;
    while (trxEndIrq !== 1'b1 && t < lim) begin
      tick(1);
      t++;
    end
    check(trxEndIrq, 1'b1);
  endtask : waitIrq

  task pulsePreamble;
    tick(20);
    preambleDetect = 1'b1;
    tick(2);
    preambleDetect = 1'b0;
  endtask : pulsePreamble

  task frame(input logic [2:0] ft, input logic ak, input logic [1:0] am,
             input logic [15:0] pan, input logic [15:0] own, input logic up, input logic ack);
    ownPan = own;
    rxHeader = '{ft, ak, am, pan, 16'hFFFF, 1'b1};
    rxFrameValid = 1'b1;
    tick(1);
    rxFrameValid = 1'b0;
    check(trxEndIrq, 1'b1);
    check(frameUpload, up);
    check(ackStart, ack);
    tick(1);
  endtask : frame

  initial begin
    {regWrite, regRead, preambleDetect, rxFrameValid, ackFrameValid, ccaRequest} = '0;
    regAddr = '0;
    regWdata = '0;
    ownPan = 16'h1234;
    rxHeader = '0;
    tick(20);
    reset_n = 1'b1;
    tick(3);
    // ----------------------------------------------------------------
    // Reset values and unmapped access
    // ----------------------------------------------------------------
    check(ccaDone, 1'b1);
    rd(SS, {`RES_SUCCESS, `STS_PLL_ON});
    rd(`REG_RETRY_CFG, `RETRY_CFG_RESET);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(`REG_RETRY_CFG, 8'h00);
    rd(`REG_RETRY_CFG, 8'h00);
    // ----------------------------------------------------------------
    // Auto-retry: acknowledged, preamble during wait, deferred listen
    // ----------------------------------------------------------------
    wr(SS, `CMD_ARET_ON);
    rd(SS, {`RES_SUCCESS, `STS_ARET_IDLE});
    wr(SS, `CMD_TX_START);
    rd(SS, {`RES_SUCCESS, `STS_ARET_BUSY});
    tick(10);
    ackFrameValid = 1'b1;
    tick(1);
    ackFrameValid = 1'b0;
    waitIrq(20);
    rd(SS, {`RES_SUCCESS, `STS_ARET_IDLE});
    // Repeat with no new download; a stray preamble early in the ack wait
    wr(SS, `CMD_TX_START);
    pulsePreamble();
    waitIrq(40000);
    check(t + 22 >= W && t + 22 <= W + 20, 1'b1);
    check(16'(rxsCnt), 16'd1);
    rd(SS, {`RES_SUCCESS, `STS_ARET_IDLE});
    check(16'(txCnt), 16'd2);
    wr(SS, `CMD_TX_START);
    rd(SS, {`RES_SUCCESS, `STS_ARET_BUSY});
    wr(SS, `CMD_RX_LISTEN);
    rd(SS, {`RES_SUCCESS, `STS_ARET_BUSY});
    pulsePreamble();
    waitIrq(40000);
    rd(SS, {`RES_NO_ACK, `STS_RX_LISTEN});
    check(16'(txCnt), 16'd3);
    // ----------------------------------------------------------------
    // Channel assessment: accepted, dropped, recovered
    // ----------------------------------------------------------------
    ccaRequest = 1'b1;
    tick(1);
    ccaRequest = 1'b0;
    check(ccaDone, 1'b0);
    tick(5);
    check(ccaDone, 1'b1);
    ccaRequest = 1'b1;
    tick(1);
    ccaRequest = 1'b0;
    tick(5);
    check(ccaDone, 1'b0);
    check(16'(ccaCnt), 16'd1);
    wr(SS, `CMD_PLL_ON);
    wr(SS, `CMD_RX_LISTEN);
    ccaRequest = 1'b1;
    tick(1);
    ccaRequest = 1'b0;
    tick(5);
    check(16'(ccaCnt), 16'd2);
    check(ccaDone, 1'b1);
    // ----------------------------------------------------------------
    // Auto-acknowledge filtering
    // ----------------------------------------------------------------
    // No scans here, only data, command and beacon reception; result keeps the last outcome
    wr(SS, `CMD_AACK_ON);
    rd(SS, {`RES_NO_ACK, `STS_AACK_ON});
    frame(`FT_DATA, 1'b1, 2'h2, 16'h1234, 16'h1234, 1'b1, 1'b1);
    frame(`FT_DATA, 1'b0, `AM_EXTENDED, `BROADCAST, 16'h1234, 1'b0, 1'b0);
    frame(`FT_COMMAND, 1'b0, `AM_EXTENDED, `BROADCAST, 16'h1234, 1'b0, 1'b0);
    frame(`FT_BEACON, 1'b0, 2'h0, 16'h1234, `BROADCAST, 1'b0, 1'b0);
    frame(`FT_BEACON, 1'b0, 2'h0, 16'h1234, 16'h1234, 1'b1, 1'b0);
    // Compliant frame without acknowledge request ends right after sending
    wr(SS, `CMD_ARET_ON);
    txAckRequest = 1'b0;
    wr(SS, `CMD_TX_START);
    waitIrq(20);
    rd(SS, {`RES_SUCCESS, `STS_ARET_IDLE});
    check(16'(txCnt), 16'd4);
    finalReport();
  end

  // Two full ack waits dominate the run time
  initial begin
    #1700000;
    errTotal++;
    finalReport();
  end
endmodule : testbench
